// File: design/adc_channel_trigger_control.sv
// channel select, trigger and conversion sequencing with Avalon-MM registers
//
// Summary of operation
// RULE1 - with continuous mode off and hardware trigger chosen, one conversion follows each trigger edge; with it on, conversions repeat.
// RULE2 - with the channel queue in use, a whole set is converted under software trigger, or under hardware trigger with multi-conversion on.
// RULE3 - the 5-bit channel code picks inputs 0-11, ground, temperature, bandgap, high or low reference, or disables the block.
// RULE4 - in queue mode, writing the all-ones code empties the channel queue.
// RULE5 - bits 31 to 8 of the trigger and status register read zero and ignore writes.
// RULE6 - the active flag in bit 7 is high from the start of a conversion until it completes or is aborted.
// RULE7 - bit 6 of the trigger and status register chooses software or hardware triggering.
// RULE8 - a write to channel control aborts a running conversion and, unless the code is all ones, starts a new one; here if software-triggered, queue off.
// RULE9 - with trigger select at 1 a conversion follows a hardware trigger edge; 0 means software trigger.
// RULE10 - in queue mode channel writes queue in order and converting waits until the queue holds the programmed depth.
// RULE11 - reserved channel codes select no input and start nothing.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "adc_ctl_defines.svh"

module adc_channel_trigger_control
    import adc_ctl_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hardware_trigger_input,
    input wire logic conv_done,
    output logic conv_start,
    output logic conv_abort,
    output logic [4:0] conv_channel,
    output source_t conv_source,
    output logic irq
);
    localparam int AW = `CFG_DEPTH_W;

    // ****************************************
    // bus slave
    // ****************************************
    logic ack_r;
    logic wr_ack;
    logic rd_ack;
    logic ctrl_wr;
    logic [4:0] wr_chan;
    logic [31:0] readdata_r;

    // one wait state: the request is answered on the second edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    // all fields sit in byte lane 0
    assign wr_ack = avs_write && ack_r && avs_byteenable[0];
    assign rd_ack = avs_read && ack_r;
    assign ctrl_wr = wr_ack && avs_address == `OFF_CTRL;
    assign wr_chan = avs_writedata[`CHAN_LSB +: `CHAN_W];

    // ****************************************
    // registers
    // ****************************************
    logic [4:0] chan_r;
    logic cont_r;
    logic trig_sel_r;
    logic [AW-1:0] depth_r;
    logic multi_r;
    logic [`IRQ_W-1:0] mask_r;
    logic [`IRQ_W-1:0] irq_st_r;
    logic [`IRQ_W-1:0] irq_ev;
    conv_state_t st_r;
    conv_state_t st_nxt;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chan_r <= `CHAN_RESET;
            cont_r <= 1'b0;
        end else if (ctrl_wr) begin
            chan_r <= wr_chan;
            cont_r <= avs_writedata[`CONT_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trig_sel_r <= 1'b0;
        end else if (wr_ack && avs_address == `OFF_TRIG) begin
            trig_sel_r <= avs_writedata[`TRIG_SEL_BIT]; // RULE7 RULE5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            depth_r <= '0;
            multi_r <= 1'b0;
        end else if (wr_ack && avs_address == `OFF_CFG) begin
            depth_r <= avs_writedata[`CFG_DEPTH_LSB +: AW];
            multi_r <= avs_writedata[`CFG_MULTI_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mask_r <= '0;
        end else if (wr_ack && avs_address == `OFF_IRQ_MASK) begin
            mask_r <= avs_writedata[`IRQ_W-1:0];
        end
    end

    // an event in the clearing read's cycle survives the clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_st_r <= '0;
        end else if (rd_ack && avs_address == `OFF_IRQ_STATUS) begin
            irq_st_r <= irq_ev;
        end else begin
            irq_st_r <= irq_st_r | irq_ev;
        end
    end

    assign irq = |(irq_st_r & mask_r);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            case (avs_address)
                `OFF_CTRL: readdata_r <= 32'({cont_r, chan_r});
                `OFF_TRIG: readdata_r <= 32'({st_r == ST_CONV,
                    trig_sel_r, 6'h00}); // RULE5 RULE6
                `OFF_CFG: readdata_r <= 32'({multi_r, depth_r});
                `OFF_IRQ_STATUS: readdata_r <= 32'(irq_st_r);
                `OFF_IRQ_MASK: readdata_r <= 32'(mask_r);
                default: readdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = readdata_r;

    // ****************************************
    // hardware trigger synchroniser
    // ****************************************
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_s3_r;
    logic hw_edge;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else begin
            trig_s1_r <= hardware_trigger_input;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    // only the rising edge counts, so a held trigger acts as a single trigger edge
    assign hw_edge = trig_s2_r && !trig_s3_r;

    // ****************************************
    // channel queue and decode
    // ****************************************
    logic fifo_mode;
    logic fifo_push;
    logic fifo_clear;
    logic end_clear;
    logic [4:0] fifo_chan;
    logic [AW:0] fifo_count;
    logic fifo_full;
    logic [AW-1:0] set_idx_r;
    logic [AW-1:0] idx_go;
    logic last_in_set;
    logic whole_set;
    logic fresh_r;
    logic [4:0] cand_chan;
    source_t cand_src;
    logic cand_ok;

    assign fifo_mode = depth_r != '0;
    assign fifo_push = ctrl_wr && fifo_mode && wr_chan != `CHAN_DISABLE;
    assign fifo_clear = (ctrl_wr && fifo_mode
        && wr_chan == `CHAN_DISABLE) || end_clear; // RULE4
    assign fifo_full = fifo_count >= {1'b0, depth_r}; // RULE10
    assign last_in_set = set_idx_r == depth_r - AW'(1);
    assign whole_set = !trig_sel_r || multi_r; // RULE2

    channel_fifo #(
        .DEPTH(FIFO_DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .clear(fifo_clear),
        .push(fifo_push), // RULE10
        .push_chan(wr_chan),
        .rd_idx(idx_go),
        .rd_chan(fifo_chan),
        .count(fifo_count)
    );

    always_comb begin
        if (st_r == ST_NEXT) begin
            idx_go = last_in_set ? '0 : set_idx_r + AW'(1);
        end else begin
            idx_go = set_idx_r;
        end
    end

    always_comb begin
        if (ctrl_wr) begin
            cand_chan = wr_chan;
        end else if (fifo_mode) begin
            cand_chan = fifo_chan;
        end else begin
            cand_chan = chan_r;
        end
    end

    channel_decode u_decode (
        .input_channel_select(cand_chan),
        .source(cand_src)
    );

    assign cand_ok = cand_src != SRC_NONE && cand_src != SRC_OFF; // RULE11

    // ****************************************
    // conversion sequencer
    // ****************************************
    logic start;
    logic abort;
    logic done_ev;
    logic conv_start_r;
    logic conv_abort_r;
    logic [4:0] conv_channel_r;
    source_t conv_source_r;

    always_comb begin
        st_nxt = st_r;
        start = 1'b0;
        abort = 1'b0;
        done_ev = 1'b0;
        end_clear = 1'b0;
        if (ctrl_wr) begin
            abort = st_r == ST_CONV; // RULE8
            if (!fifo_mode && !trig_sel_r && cand_ok) begin
                start = 1'b1; // RULE8
            end
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (fifo_mode) begin
                        start = fifo_full && cand_ok
                            && ((!trig_sel_r && fresh_r)
                            || (trig_sel_r && hw_edge)); // RULE2 RULE10
                    end else begin
                        start = trig_sel_r && hw_edge && cand_ok; // RULE9
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        st_nxt = ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (fifo_mode && whole_set && !last_in_set) begin
                        start = cand_ok; // RULE2
                    end else begin
                        done_ev = 1'b1;
                        start = cont_r && cand_ok; // RULE1
                        end_clear = fifo_mode && !trig_sel_r && !start;
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
        if (start) begin
            st_nxt = ST_CONV;
        end else if (ctrl_wr || st_r == ST_NEXT) begin
            st_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt; // RULE6
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || fifo_clear || ctrl_wr) begin
            set_idx_r <= '0;
        end else begin
            set_idx_r <= idx_go;
        end
    end

    // a queue becomes fresh on each push, so a software set runs once
    always_ff @(posedge clk_sys) begin
        if (reset || fifo_clear || start) begin
            fresh_r <= 1'b0;
        end else if (fifo_push) begin
            fresh_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_start_r <= 1'b0;
            conv_abort_r <= 1'b0;
            conv_channel_r <= `CHAN_RESET;
            conv_source_r <= SRC_OFF;
        end else begin
            conv_start_r <= start;
            conv_abort_r <= abort;
            if (start) begin
                conv_channel_r <= cand_chan;
                conv_source_r <= cand_src;
            end
        end
    end

    assign irq_ev = {abort, done_ev};
    assign conv_start = conv_start_r;
    assign conv_abort = conv_abort_r;
    assign conv_channel = conv_channel_r;
    assign conv_source = conv_source_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_sw_write_start: assert property ( // RULE8
        ctrl_wr && !trig_sel_r && !fifo_mode && cand_ok
        |=> conv_start && conv_channel == $past(wr_chan) && st_r == ST_CONV)
        else $error("software write did not start a conversion");
    a_write_abort: assert property ( // RULE8
        ctrl_wr && st_r == ST_CONV |=> conv_abort && irq_st_r[1])
        else $error("write during conversion did not abort");
    a_active_flag: assert property ( // RULE6
        st_r == ST_CONV && conv_done && !ctrl_wr
        |=> st_r != ST_CONV ##1 !conv_start || st_r == ST_CONV)
        else $error("active flag not cleared on completion");
    a_hw_edge_start: assert property ( // RULE9
        st_r == ST_IDLE && trig_sel_r && hw_edge && !fifo_mode
        && cand_ok && !ctrl_wr |=> conv_start)
        else $error("hardware trigger edge did not start");
    a_hw_one_shot: assert property ( // RULE1
        st_r == ST_IDLE && trig_sel_r && !hw_edge && !ctrl_wr
        && !fifo_mode |=> !conv_start)
        else $error("conversion without hardware trigger");
    a_cont_restart: assert property ( // RULE1
        st_r == ST_NEXT && cont_r && !fifo_mode && cand_ok && !ctrl_wr
        |=> conv_start && $past(irq_ev[0]))
        else $error("continuous mode did not restart");
    a_fifo_wait: assert property ( // RULE10
        fifo_mode && !fifo_full && st_r == ST_IDLE && !ctrl_wr
        |=> !conv_start)
        else $error("queue converted before reaching depth");
    a_fifo_set: assert property ( // RULE2
        st_r == ST_NEXT && fifo_mode && whole_set && !last_in_set
        && cand_ok && !ctrl_wr |=> conv_start ##1 !conv_start)
        else $error("set did not continue to next entry");
    a_disable_clear: assert property ( // RULE4
        ctrl_wr && fifo_mode && wr_chan == `CHAN_DISABLE
        |=> fifo_count == '0 && !conv_start)
        else $error("disable code did not empty the queue");
    a_upper_zero: assert property ( // RULE5
        rd_ack && avs_address == `OFF_TRIG |-> avs_readdata[31:8] == '0
        && avs_readdata[7] == $past(st_r == ST_CONV))
        else $error("trigger register upper bits not zero");
    a_no_reserved: assert property ( // RULE11
        conv_start |-> conv_source != SRC_NONE && conv_source != SRC_OFF)
        else $error("conversion started on invalid code");
endmodule

// File: design/adc_ctl_defines.svh
// offsets, field positions and reset values of the channel trigger block
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

`define OFF_CTRL 5'h00
`define OFF_TRIG 5'h04
`define OFF_CFG 5'h08
`define OFF_IRQ_STATUS 5'h0c
`define OFF_IRQ_MASK 5'h10

`define CHAN_W 5
`define CHAN_LSB 0
`define CONT_BIT 5
`define TRIG_SEL_BIT 6
`define ACTIVE_BIT 7
`define CFG_DEPTH_W 3
`define CFG_DEPTH_LSB 0
`define CFG_MULTI_BIT 3
`define IRQ_W 2
`define IRQ_DONE_BIT 0
`define IRQ_ABORT_BIT 1

`define CHAN_RESET 5'h1f
`define CHAN_DISABLE 5'h1f
`define CHAN_EXT_LAST 5'h0b
`define CHAN_GND_LAST 5'h13
`define CHAN_TEMP 5'h16
`define CHAN_BANDGAP 5'h17
`define CHAN_REFH 5'h1d
`define CHAN_REFL 5'h1e

`endif

// File: design/adc_ctl_pkg.sv
// types shared by the channel trigger block
package adc_ctl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_NEXT = 2'b11
    } conv_state_t;

    typedef enum logic [2:0] {
        SRC_EXT = 3'h0,
        SRC_GROUND = 3'h1,
        SRC_TEMP = 3'h2,
        SRC_BANDGAP = 3'h3,
        SRC_REFH = 3'h4,
        SRC_REFL = 3'h5,
        SRC_OFF = 3'h6,
        SRC_NONE = 3'h7
    } source_t;
endpackage

// File: design/channel_decode.sv
// decode of the input channel select code into a source class
`timescale 1ns/1ps
`include "adc_ctl_defines.svh"

module channel_decode
    import adc_ctl_pkg::*;
(
    input wire logic [4:0] input_channel_select,
    output source_t source
);
    always_comb begin
        if (input_channel_select <= `CHAN_EXT_LAST) begin
            source = SRC_EXT; // RULE3
        end else if (input_channel_select <= `CHAN_GND_LAST) begin
            source = SRC_GROUND; // RULE3
        end else begin
            case (input_channel_select)
                `CHAN_TEMP: source = SRC_TEMP; // RULE3
                `CHAN_BANDGAP: source = SRC_BANDGAP; // RULE3
                `CHAN_REFH: source = SRC_REFH; // RULE3
                `CHAN_REFL: source = SRC_REFL; // RULE3
                `CHAN_DISABLE: source = SRC_OFF; // RULE3
                default: source = SRC_NONE; // RULE11
            endcase
        end
    end
endmodule

// File: design/channel_fifo.sv
// queue of channel codes, read back by index for the conversion set
`timescale 1ns/1ps

module channel_fifo #(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clear,
    input wire logic push,
    input wire logic [4:0] push_chan,
    input wire logic [AW-1:0] rd_idx,
    output logic [4:0] rd_chan,
    output logic [AW:0] count
);
    logic [4:0] mem_r [DEPTH];
    logic [AW:0] count_r;
    logic do_push;

    // a push into a full queue is dropped; software must clear first
    assign do_push = push && (count_r < (AW+1)'(DEPTH));

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    mem_r[i] <= 5'h00;
                end else if (do_push && count_r[AW-1:0] == AW'(i)) begin
                    mem_r[i] <= push_chan;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset || clear) begin
            count_r <= '0;
        end else if (do_push) begin
            count_r <= count_r + (AW+1)'(1);
        end
    end

    assign rd_chan = mem_r[rd_idx];
    assign count = count_r;
endmodule

// File: testbench/conv_core_model.sv
// behavioural converter core: answers each start that is not aborted with a done pulse
`timescale 1ns/1ps

module conv_core_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic conv_start,
    input wire logic conv_abort,
    input wire logic [3:0] lat,
    output logic conv_done
);
    // ************************************************************
    // conversion timer
    // ************************************************************
    int cnt;
    // a start in the abort cycle wins: the device restarts at once
    always @(posedge clk_sys) begin
        conv_done <= 1'b0;
        if (reset) begin
            cnt <= 0;
        end else if (conv_start) begin
            cnt <= (lat < 2) ? 2 : lat;
        end else if (conv_abort) begin
            cnt <= 0;
        end else if (cnt == 1) begin
            conv_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// File: testbench/testbench.sv
// self-checking bench of the channel trigger block
`timescale 1ns/1ps
`include "adc_ctl_defines.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
    end end

module testbench
    import adc_ctl_pkg::*;
;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic hw_trig;
    logic conv_done, conv_start, conv_abort, irq;
    logic [4:0] conv_channel;
    source_t conv_source;
    logic [3:0] lat;
    logic [31:0] q;
    int err_total = 0;
    int compares = 0;
    int n_start = 0;
    int n_abort = 0;
    int free_ch = -1;
    int exp_q[$];
    int seed = 32'hb752f6f0;
    int n0;

    always #10 clk_sys = ~clk_sys;

    adc_channel_trigger_control #(.FIFO_DEPTH(8)) adc_channel_trigger_control_i (
        .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .hardware_trigger_input(hw_trig), .conv_done(conv_done),
        .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_channel(conv_channel), .conv_source(conv_source), .irq(irq));

    conv_core_model conv_core_model_i (
        .clk_sys(clk_sys), .reset(reset), .conv_start(conv_start),
        .conv_abort(conv_abort), .lat(lat), .conv_done(conv_done));

    // ************************************************************
    // reference model
    // ************************************************************
    function automatic source_t src_of(input int c);
        if (c <= 'h0b) return SRC_EXT;
        if (c <= 'h13) return SRC_GROUND;
        if (c == 'h16) return SRC_TEMP;
        if (c == 'h17) return SRC_BANDGAP;
        if (c == 'h1d) return SRC_REFH;
        if (c == 'h1e) return SRC_REFL;
        if (c == 'h1f) return SRC_OFF;
        return SRC_NONE;
    endfunction

    // every start is held against the queue of expected channels, or against free_ch when it is empty
    always @(posedge clk_sys) begin
        int e;
        if (!reset && conv_start === 1'b1) begin
            n_start++;
            e = -1;
            if (exp_q.size() > 0) e = exp_q.pop_front();
            else e = free_ch;
            `CHK("conv_channel", e[4:0], conv_channel)
            `CHK("conv_source", src_of(e), conv_source)
        end
        if (!reset && conv_abort === 1'b1) n_abort++;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results();
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bus(input bit w, input logic [4:0] a,
                       input logic [31:0] d);
        int k;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        k = 0;
        // values read here are those that stood just before the edge
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (k >= 20) begin
            err_total++;
            results();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // one idle edge so the next call never re-raises in this step
        @(posedge clk_sys);
    endtask

    task automatic pulse_trig();
        hw_trig <= 1'b1;
        repeat (3) @(posedge clk_sys);
        hw_trig <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        `CHK("pending starts", 0, exp_q.size())
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        results();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        avs_address <= 5'h00;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h0;
        avs_byteenable <= 4'hf;
        hw_trig <= 1'b0;
        lat <= 4'h5;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        bus(0, `OFF_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h1f, q)
        bus(0, `OFF_TRIG, 32'h0);
        `CHK("trig reset", 32'h0, q)
        `CHK("channel reset", 5'h1f, conv_channel)
        bus(1, `OFF_TRIG, ($random(seed) & 32'hffffffbf) | 32'h80);
        bus(0, `OFF_TRIG, 32'h0);
        `CHK("trig upper", 32'h0, q)
        bus(1, `OFF_TRIG, $random(seed) | 32'h40);
        bus(0, `OFF_TRIG, 32'h0);
        `CHK("trig select", 32'h40, q)
        bus(1, `OFF_TRIG, 32'h0);
        // a write without byte lane 0 must leave the select alone
        avs_byteenable <= 4'he;
        bus(1, `OFF_TRIG, 32'h40);
        avs_byteenable <= 4'hf;
        bus(0, `OFF_TRIG, 32'h0);
        `CHK("lane 0 off", 32'h0, q)
        bus(1, `OFF_IRQ_MASK, 32'h3);
        // every channel code once, software trigger
        for (int c = 0; c < 32; c++) begin
            lat <= 4'h2 + 4'($unsigned($random(seed)) % 8);
            if (src_of(c) != SRC_NONE && src_of(c) != SRC_OFF) exp_q.push_back(c);
            bus(1, `OFF_CTRL, 32'(c));
            settle(16);
        end
        `CHK("irq done", 1'b1, irq)
        bus(0, `OFF_IRQ_STATUS, 32'h0);
        `CHK("status done", 32'h1, q)
        `CHK("irq clear", 1'b0, irq)
        // abort by rewrite, then by the disable code
        lat <= 4'hf;
        exp_q.push_back(3);
        n0 = n_abort;
        bus(1, `OFF_CTRL, 32'h3);
        bus(0, `OFF_TRIG, 32'h0);
        `CHK("active", 32'h80, q)
        exp_q.push_back(4);
        bus(1, `OFF_CTRL, 32'h4);
        settle(24);
        bus(0, `OFF_TRIG, 32'h0);
        `CHK("idle", 32'h0, q)
        exp_q.push_back(5);
        bus(1, `OFF_CTRL, 32'h5);
        bus(1, `OFF_CTRL, 32'h1f);
        settle(24);
        `CHK("aborts", 2, n_abort - n0)
        bus(0, `OFF_IRQ_STATUS, 32'h0);
        `CHK("status abort", 32'h3, q)
        // hardware trigger, one conversion per edge, then repeats in continuous mode
        lat <= 4'h6;
        bus(1, `OFF_TRIG, 32'h40);
        bus(1, `OFF_CTRL, 32'h2);
        settle(10);
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back(2);
            pulse_trig();
            settle(24);
        end
        free_ch = 2;
        n0 = n_start;
        bus(1, `OFF_CTRL, 32'h22);
        pulse_trig();
        repeat (60) @(posedge clk_sys);
        `CHK("repeats", 1'b1, (n_start - n0) >= 3)
        bus(1, `OFF_CTRL, 32'h1f);
        repeat (20) @(posedge clk_sys);
        free_ch = -1;
        // channel queue, software set with a queue reset in between
        bus(1, `OFF_TRIG, 32'h0);
        bus(1, `OFF_CFG, 32'h2);
        bus(1, `OFF_CTRL, 32'h9);
        bus(1, `OFF_CTRL, 32'h1f);
        bus(1, `OFF_CTRL, 32'ha);
        settle(8);
        exp_q.push_back('ha);
        exp_q.push_back('hb);
        bus(1, `OFF_CTRL, 32'hb);
        settle(40);
        // whole set under hardware trigger with multi-conversion
        bus(1, `OFF_CFG, 32'ha);
        bus(1, `OFF_TRIG, 32'h40);
        bus(1, `OFF_CTRL, 32'hc);
        bus(1, `OFF_CTRL, 32'hd);
        settle(8);
        exp_q.push_back('hc);
        exp_q.push_back('hd);
        pulse_trig();
        settle(40);
        // same queue, multi-conversion off: one entry per trigger edge
        bus(1, `OFF_CFG, 32'h2);
        for (int i = 0; i < 2; i++) begin
            exp_q.push_back('hc + i);
            pulse_trig();
            settle(24);
        end
        results();
    end
endmodule
